/* File: shared/eeprom_regs.svh */
`ifndef EEPROM_REGS_SVH
`define EEPROM_REGS_SVH
// Function
// - Protect pin high: no array or flag writes
// - Protect pin low has no effect
// - Any lock flag blocks lower 128 bytes
// - Permanent flag set only, never cleared
// - Reversible flag has set and clear
// - Master applies high voltage, fixed select pins
// - Both lock flags cleared at delivery
// - Lock read byte: inverted flags in bits 1..0
// - Permanent set: write framing, three acks, commit
// - Lock command slave byte encodings
// - Permanent flag set: no lock set or clear command acked
// - Protected flip: address acked, data not
// - Reaffirming lock command: slave byte not acked
// - Counter points past last byte, wraps
// - Read slave byte acked, byte shifted out
// - Master ends read with no-ack then stop
// - Random read: dummy write loads counter
// - Every array read byte increments counter, acked or not, wraps
// - Normal preamble 1010, select match, direction
// - 256 bytes, 16 pages of 16, 8-bit counter
// - Busy writing: slave address not acked

`define PRE_NORMAL 4'ha
`define PRE_LOCK 4'h6
`define REV_SET_LOW 4'h2
`define REV_CLEAR_LOW 4'h6
`define REV_SET_SEL 2'h0
`define REV_CLEAR_SEL 2'h1
`define LOCK_JUNK 6'h00
`define ERASED_BYTE 8'hff
`define MEM_BYTES 256
`define CLK_MHZ 100
`define WRITE_CYCLE_US 5000
`define WRITE_CYCLES (`WRITE_CYCLE_US * `CLK_MHZ)
`define QUARTER_CYCLES 4
`endif

/* File: shared/eeprom_pkg.sv */
package eeprom_pkg;
  typedef enum logic [2:0] {
    slvIdle, slvDevAddr, slvWordAddr, slvWrData,
    slvRdData, slvLockAddr, slvLockData
  } slave_state_type;
  typedef enum logic [2:0] {
    addrNone, addrMemWrite, addrMemRead, addrLockRead,
    addrPermSet, addrRevSet, addrRevClear
  } addr_kind_type;
  typedef enum logic [2:0] {
    cmdWrite, cmdReadCurrent, cmdReadRandom, cmdLockRead,
    cmdPermSet, cmdRevSet, cmdRevClear
  } cmd_type;
  typedef enum logic [1:0] {opStart, opSend, opRecv, opStop} op_type;
endpackage

/* File: shared/eeprom_link_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface eeprom_link_if;
  logic scl;
  logic masterSdaOe;
  logic slaveSdaOe;
  logic sda;
  logic [2:0] selectPin;
  logic highVoltageLevel;
  // Open-drain wired AND, pulled up when nobody drives
  assign sda = ~(masterSdaOe | slaveSdaOe);
  modport master(output scl, output masterSdaOe, output selectPin,
    output highVoltageLevel, input sda);
  modport slave(input scl, input sda, input selectPin,
    input highVoltageLevel, output slaveSdaOe);
endinterface
`default_nettype wire

/* File: logic/eeprom_slave.sv */
`timescale 1ns/10ps
`default_nettype none
`include "eeprom_regs.svh"
module eeprom_slave
  import eeprom_pkg::*;
#(
  parameter int WRITE_CYCLES = `WRITE_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  eeprom_link_if.slave link,
  input wire logic writeProtect,
  output logic permanentLockFlag,
  output logic reversibleLockFlag,
  output logic busy
);
  localparam int CW = $clog2(WRITE_CYCLES + 1);

  // ==========================================================
  // Pin synchronisers and bus conditions
  logic [1:0] sclSync, sdaSync, wpSync, hvSync;
  logic [2:0] selA, selB;
  logic sclPrev, sdaPrev;
  logic sclRise, sclFall, startCond, stopCond;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sclSync <= 2'h3;
      sdaSync <= 2'h3;
      wpSync <= 2'h0;
      hvSync <= 2'h0;
      selA <= 3'h0;
      selB <= 3'h0;
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
    end else begin
      sclSync <= {sclSync[0], link.scl};
      sdaSync <= {sdaSync[0], link.sda};
      wpSync <= {wpSync[0], writeProtect};
      hvSync <= {hvSync[0], link.highVoltageLevel};
      selA <= link.selectPin;
      selB <= selA;
      sclPrev <= sclSync[1];
      sdaPrev <= sdaSync[1];
    end
  end

  assign sclRise = sclSync[1] & ~sclPrev;
  assign sclFall = ~sclSync[1] & sclPrev;
  assign startCond = sclSync[1] & sclPrev & sdaPrev & ~sdaSync[1];
  assign stopCond = sclSync[1] & sclPrev & ~sdaPrev & sdaSync[1];

  // ==========================================================
  // Slave byte decode
  function automatic addr_kind_type devKind(input logic [7:0] b,
      input logic [2:0] sel, input logic hv);
    addr_kind_type k;
    k = addrNone;
    if (b[7:4] == `PRE_NORMAL && b[3:1] == sel) begin
      k = b[0] ? addrMemRead : addrMemWrite;
    end else if (b[7:4] == `PRE_LOCK) begin
      if (hv && b[3:0] == `REV_SET_LOW && sel[2:1] == `REV_SET_SEL) begin
        k = addrRevSet;
      end else if (hv && b[3:0] == `REV_CLEAR_LOW &&
          sel[2:1] == `REV_CLEAR_SEL) begin
        k = addrRevClear;
      end else if (b[3:1] == sel) begin
        k = b[0] ? addrLockRead : addrPermSet;
      end
    end
    return k;
  endfunction

  // ==========================================================
  // Array
  logic [7:0] mem [`MEM_BYTES];
  logic memWe;
  logic [7:0] memAddr, memData;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < `MEM_BYTES; i++) begin
        mem[i] <= `ERASED_BYTE;
      end
    end else if (memWe) begin
      mem[memAddr] <= memData;
    end
  end

  // ==========================================================
  // Serial engine
  slave_state_type state, nextState;
  addr_kind_type cmdKind, kind;
  logic [3:0] bitCnt;
  logic [7:0] shiftIn, txByte, readByte, addrCount;
  logic masterAck, dirty, commitReq, softLock, wouldChange;

  assign kind = devKind(shiftIn, selB, hvSync[1]);
  assign softLock = permanentLockFlag | reversibleLockFlag;
  assign wouldChange = (kind == addrPermSet) ? ~permanentLockFlag :
    (kind == addrRevSet) ? ~reversibleLockFlag :
    (kind == addrRevClear) ? reversibleLockFlag : 1'b0;
  assign readByte = (cmdKind == addrLockRead) ?
    {`LOCK_JUNK, ~permanentLockFlag, ~reversibleLockFlag} :
    mem[addrCount];

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= slvIdle;
      nextState <= slvIdle;
      cmdKind <= addrNone;
      bitCnt <= 4'h0;
      shiftIn <= 8'h00;
      txByte <= 8'h00;
      addrCount <= 8'h00;
      masterAck <= 1'b0;
      dirty <= 1'b0;
      commitReq <= 1'b0;
      memWe <= 1'b0;
      memAddr <= 8'h00;
      memData <= 8'h00;
      link.slaveSdaOe <= 1'b0;
    end else begin
      memWe <= 1'b0;
      commitReq <= 1'b0;
      if (startCond) begin
        state <= slvDevAddr;
        // The start's own clock fall wraps this to zero
        bitCnt <= 4'hf;
        link.slaveSdaOe <= 1'b0;
      end else if (stopCond) begin
        state <= slvIdle;
        bitCnt <= 4'h0;
        link.slaveSdaOe <= 1'b0;
        commitReq <= dirty;
        dirty <= 1'b0;
      end else if (state != slvIdle && sclRise) begin
        if (bitCnt == 4'h8) begin
          masterAck <= ~sdaSync[1];
        end else begin
          shiftIn <= {shiftIn[6:0], sdaSync[1]};
        end
      end else if (state != slvIdle && sclFall) begin
        if (bitCnt == 4'h7) begin
          bitCnt <= 4'h8;
          link.slaveSdaOe <= 1'b0;
          nextState <= slvIdle;
          case (state)
            slvDevAddr: begin
              cmdKind <= kind;
              if (busy) begin
                nextState <= slvIdle;
              end else if (kind == addrMemWrite) begin
                link.slaveSdaOe <= 1'b1;
                nextState <= slvWordAddr;
              end else if (kind == addrMemRead ||
                  kind == addrLockRead) begin
                link.slaveSdaOe <= 1'b1;
                nextState <= slvRdData;
              end else if (kind != addrNone && !permanentLockFlag &&
                  wouldChange) begin
                link.slaveSdaOe <= 1'b1;
                nextState <= slvLockAddr;
              end
            end
            slvWordAddr: begin
              link.slaveSdaOe <= 1'b1;
              addrCount <= shiftIn;
              nextState <= slvWrData;
            end
            slvWrData: begin
              if (!wpSync[1] && !(softLock && !addrCount[7])) begin
                link.slaveSdaOe <= 1'b1;
                memWe <= 1'b1;
                memAddr <= addrCount;
                memData <= shiftIn;
                addrCount[3:0] <= addrCount[3:0] + 4'h1;
                dirty <= 1'b1;
                nextState <= slvWrData;
              end
            end
            slvLockAddr: begin
              link.slaveSdaOe <= 1'b1;
              nextState <= slvLockData;
            end
            slvLockData: begin
              if (!wpSync[1]) begin
                link.slaveSdaOe <= 1'b1;
                dirty <= 1'b1;
                nextState <= slvLockData;
              end
            end
            slvRdData: begin
              if (cmdKind == addrMemRead) begin
                addrCount <= addrCount + 8'h01;
              end
              nextState <= slvRdData;
            end
            default: nextState <= slvIdle;
          endcase
        end else if (bitCnt == 4'h8) begin
          bitCnt <= 4'h0;
          if (nextState == slvRdData &&
              (state != slvRdData || masterAck)) begin
            state <= slvRdData;
            txByte <= readByte;
            link.slaveSdaOe <= ~readByte[7];
          end else begin
            // No-ack from master ends the read
            link.slaveSdaOe <= 1'b0;
            state <= (nextState == slvRdData) ? slvIdle : nextState;
          end
        end else begin
          bitCnt <= bitCnt + 4'h1;
          if (state == slvRdData) begin
            txByte <= {txByte[6:0], 1'b0};
            link.slaveSdaOe <= ~txByte[6];
          end
        end
      end
    end
  end

  // ==========================================================
  // Internal write cycle and lock flags
  logic [CW-1:0] busyCnt;
  addr_kind_type pendKind;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      busy <= 1'b0;
      busyCnt <= '0;
      pendKind <= addrNone;
      permanentLockFlag <= 1'b0;
      reversibleLockFlag <= 1'b0;
    end else if (commitReq) begin
      busy <= 1'b1;
      busyCnt <= CW'(WRITE_CYCLES - 1);
      pendKind <= cmdKind;
    end else if (busy) begin
      if (busyCnt == '0) begin
        busy <= 1'b0;
        pendKind <= addrNone;
        case (pendKind)
          addrPermSet: permanentLockFlag <= 1'b1;
          addrRevSet: reversibleLockFlag <= 1'b1;
          addrRevClear: reversibleLockFlag <= 1'b0;
          default: ;
        endcase
      end else begin
        busyCnt <= busyCnt - CW'(1);
      end
    end
  end
endmodule
`default_nettype wire

/* File: logic/eeprom_master.sv */
`timescale 1ns/10ps
`default_nettype none
`include "eeprom_regs.svh"
module eeprom_master
  import eeprom_pkg::*;
#(
  parameter int QUARTER = `QUARTER_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  eeprom_link_if.master link,
  input wire logic [2:0] selectCfg,
  input wire logic cmdValid,
  input wire cmd_type cmdKind,
  input wire logic [7:0] cmdAddr,
  input wire logic [7:0] cmdData,
  input wire logic [3:0] cmdCount,
  output logic cmdBusy,
  output logic rdValid,
  output logic [7:0] rdData,
  output logic nackSeen
);
  localparam int QW = $clog2(QUARTER + 1);

  // ==========================================================
  // Command sequencing
  function automatic op_type opFor(input cmd_type k, input logic [2:0] s);
    op_type o;
    o = opStop;
    case (k)
      cmdReadCurrent, cmdLockRead: begin
        case (s)
          3'h0: o = opStart;
          3'h1: o = opSend;
          3'h2: o = opRecv;
          default: o = opStop;
        endcase
      end
      cmdReadRandom: begin
        case (s)
          3'h0, 3'h3: o = opStart;
          3'h1, 3'h2, 3'h4: o = opSend;
          3'h5: o = opRecv;
          default: o = opStop;
        endcase
      end
      default: begin
        case (s)
          3'h0: o = opStart;
          3'h1, 3'h2, 3'h3: o = opSend;
          default: o = opStop;
        endcase
      end
    endcase
    return o;
  endfunction

  cmd_type kind;
  logic [2:0] step;
  logic [1:0] q;
  logic [3:0] bitIdx, remain;
  logic [7:0] addrReg, dataReg, txCur, rxByte;
  logic [QW-1:0] quarterCnt;
  logic [1:0] sdaSync;
  logic abort, tick;
  op_type op;

  assign op = abort ? opStop : opFor(kind, step);
  assign tick = cmdBusy && quarterCnt == '0;

  always_comb begin
    txCur = {`PRE_NORMAL, link.selectPin, 1'b0};
    case (kind)
      cmdReadCurrent: txCur = {`PRE_NORMAL, link.selectPin, 1'b1};
      cmdLockRead: txCur = {`PRE_LOCK, link.selectPin, 1'b1};
      cmdPermSet: txCur = {`PRE_LOCK, link.selectPin, 1'b0};
      cmdRevSet: txCur = {`PRE_LOCK, `REV_SET_LOW};
      cmdRevClear: txCur = {`PRE_LOCK, `REV_CLEAR_LOW};
      default: txCur = {`PRE_NORMAL, link.selectPin, 1'b0};
    endcase
    if (step == 3'h2) begin
      txCur = addrReg;
    end else if (step == 3'h3) begin
      txCur = dataReg;
    end else if (step == 3'h4) begin
      txCur = {`PRE_NORMAL, link.selectPin, 1'b1};
    end
  end

  // ==========================================================
  // Clock divider and data synchroniser
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      quarterCnt <= '0;
      sdaSync <= 2'h3;
    end else begin
      sdaSync <= {sdaSync[0], link.sda};
      if (!cmdBusy || quarterCnt == '0) begin
        quarterCnt <= QW'(QUARTER - 1);
      end else begin
        quarterCnt <= quarterCnt - QW'(1);
      end
    end
  end

  // ==========================================================
  // Bit engine: four quarters per bit, clock high in the middle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cmdBusy <= 1'b0;
      kind <= cmdWrite;
      step <= 3'h0;
      q <= 2'h0;
      bitIdx <= 4'h0;
      remain <= 4'h0;
      addrReg <= 8'h00;
      dataReg <= 8'h00;
      rxByte <= 8'h00;
      rdData <= 8'h00;
      rdValid <= 1'b0;
      nackSeen <= 1'b0;
      abort <= 1'b0;
      link.scl <= 1'b1;
      link.masterSdaOe <= 1'b0;
      link.selectPin <= 3'h0;
      link.highVoltageLevel <= 1'b0;
    end else begin
      rdValid <= 1'b0;
      if (!cmdBusy) begin
        link.selectPin <= selectCfg;
        link.highVoltageLevel <= 1'b0;
        if (cmdValid) begin
          cmdBusy <= 1'b1;
          kind <= cmdKind;
          step <= 3'h0;
          q <= 2'h0;
          bitIdx <= 4'h0;
          remain <= cmdCount;
          addrReg <= cmdAddr;
          dataReg <= cmdData;
          nackSeen <= 1'b0;
          abort <= 1'b0;
          if (cmdKind == cmdRevSet) begin
            link.selectPin <= {`REV_SET_SEL, selectCfg[0]};
            link.highVoltageLevel <= 1'b1;
          end else if (cmdKind == cmdRevClear) begin
            link.selectPin <= {`REV_CLEAR_SEL, selectCfg[0]};
            link.highVoltageLevel <= 1'b1;
          end
        end
      end else if (tick) begin
        q <= q + 2'h1;
        case (op)
          opStart: begin
            case (q)
              2'h0: link.masterSdaOe <= 1'b0;
              2'h1: link.scl <= 1'b1;
              2'h2: link.masterSdaOe <= 1'b1;
              default: begin
                link.scl <= 1'b0;
                step <= step + 3'h1;
              end
            endcase
          end
          opStop: begin
            case (q)
              2'h0: link.masterSdaOe <= 1'b1;
              2'h1: link.scl <= 1'b1;
              2'h2: link.masterSdaOe <= 1'b0;
              default: cmdBusy <= 1'b0;
            endcase
          end
          default: begin
            case (q)
              2'h0: begin
                if (bitIdx == 4'h8) begin
                  link.masterSdaOe <= (op == opRecv) && remain > 4'h1;
                end else begin
                  link.masterSdaOe <= (op == opSend) &&
                    !txCur[3'(4'h7 - bitIdx)];
                end
              end
              2'h1: link.scl <= 1'b1;
              2'h2: begin
                if (bitIdx != 4'h8) begin
                  rxByte <= {rxByte[6:0], sdaSync[1]};
                end else if (op == opSend && sdaSync[1]) begin
                  nackSeen <= 1'b1;
                end
              end
              default: begin
                link.scl <= 1'b0;
                if (bitIdx != 4'h8) begin
                  bitIdx <= bitIdx + 4'h1;
                end else begin
                  bitIdx <= 4'h0;
                  // Abort once the clock is low, so a real stop follows
                  abort <= nackSeen;
                  if (op == opRecv) begin
                    rdValid <= 1'b1;
                    rdData <= rxByte;
                  end
                  if (op == opRecv && remain > 4'h1) begin
                    remain <= remain - 4'h1;
                  end else begin
                    step <= step + 3'h1;
                  end
                end
              end
            endcase
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

/* File: bench/eeprom_link_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
module eeprom_link_assertions (
  input wire logic clk,
  input wire logic resetn,
  input wire logic scl,
  input wire logic masterSdaOe,
  input wire logic slaveSdaOe,
  input wire logic sda,
  input wire logic [2:0] selectPin,
  input wire logic highVoltageLevel
);
  // ====================
  // Link rules
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  a_reset_idle: assert property ($rose(resetn) |-> scl && !masterSdaOe
    && !slaveSdaOe && !highVoltageLevel) else $error("link busy at reset");
  a_slave_moves_low: assert property ($changed(slaveSdaOe) |->
    !scl && !$past(scl) && !$past(scl, 2)) else $error("slave moved data");
  a_slave_release: assert property ($rose(slaveSdaOe) |->
    ##[1:160] !slaveSdaOe) else $error("slave holds data too long");
  a_scl_low_min: assert property ($fell(scl) |-> !scl [*8])
    else $error("clock low too short");
  a_scl_high_min: assert property ($rose(scl) |-> scl [*8])
    else $error("clock high too short");
  a_hv_pins_fixed: assert property (highVoltageLevel |-> !selectPin[2])
    else $error("select pin two high with high voltage");
  a_hv_rise_idle: assert property ($rose(highVoltageLevel) |-> scl && sda)
    else $error("high voltage raised inside frame");
  a_hv_pins_steady: assert property (highVoltageLevel && !scl |->
    $stable(selectPin)) else $error("select pins moved in frame");
  a_hv_fall_idle: assert property ($fell(highVoltageLevel) |-> scl && sda)
    else $error("high voltage dropped before stop");
endmodule
`default_nettype wire

/* File: bench/tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
  import eeprom_pkg::*;
  logic clk;
  logic resetn;
  logic writeProtect;
  logic [2:0] selectCfg;
  logic cmdValid;
  cmd_type cmdKind;
  logic [7:0] cmdAddr;
  logic [7:0] cmdData;
  logic [3:0] cmdCount;
  logic cmdBusy, rdValid, nackSeen;
  logic [7:0] rdData;
  logic permanentLockFlag, reversibleLockFlag, busy;
  int n_fail = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [7:0] got[$];
  eeprom_link_if link();
  eeprom_master #(.QUARTER(4)) eeprom_master_i (.clk(clk), .resetn(resetn),
    .link(link.master), .selectCfg(selectCfg), .cmdValid(cmdValid),
    .cmdKind(cmdKind), .cmdAddr(cmdAddr), .cmdData(cmdData),
    .cmdCount(cmdCount), .cmdBusy(cmdBusy), .rdValid(rdValid),
    .rdData(rdData), .nackSeen(nackSeen));
  // Write cycle outlasts one slave byte, so busy refusal is seen
  eeprom_slave #(.WRITE_CYCLES(300)) eeprom_slave_i (.clk(clk),
    .resetn(resetn), .link(link.slave), .writeProtect(writeProtect),
    .permanentLockFlag(permanentLockFlag),
    .reversibleLockFlag(reversibleLockFlag), .busy(busy));
  eeprom_link_assertions eeprom_link_assertions_i (.clk(clk),
    .resetn(resetn), .scl(link.scl), .masterSdaOe(link.masterSdaOe),
    .slaveSdaOe(link.slaveSdaOe), .sda(link.sda),
    .selectPin(link.selectPin), .highVoltageLevel(link.highVoltageLevel));
  // ====================
  // Clock, timeout, capture
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (rdValid === 1'b1) begin
      got.push_back(rdData);
    end
    if (cycles == 60000) begin
      n_fail++;
      stop_test();
    end
  end
  // ====================
  // Shared tasks
  task stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task chk(input logic [7:0] g, input logic [7:0] e, input string m);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task run_cmd(input cmd_type k, input logic [7:0] a, input logic [7:0] d,
    input logic [3:0] n);
    int i;
    got.delete();
    @(posedge clk);
    cmdKind <= k;
    cmdAddr <= a;
    cmdData <= d;
    cmdCount <= n;
    cmdValid <= 1'b1;
    @(posedge clk);
    cmdValid <= 1'b0;
    i = 0;
    @(posedge clk);
    #1;
    while (cmdBusy !== 1'b0 && i < 4000) begin
      @(posedge clk);
      #1;
      i++;
    end
    if (i >= 4000) chk(8'h00, 8'h01, "command hung");
  endtask
  // Slave busy starts a few clocks after the stop
  task wait_ready;
    int i;
    i = 0;
    repeat (4) @(posedge clk);
    #1;
    while (busy !== 1'b0 && i < 400) begin
      @(posedge clk);
      #1;
      i++;
    end
    if (i >= 400) chk(8'h00, 8'h01, "write cycle hung");
  endtask
  // ====================
  // Scenarios
  task t_delivery;
    chk({6'h0, permanentLockFlag, reversibleLockFlag}, 8'h00, "flags");
    run_cmd(cmdLockRead, 8'h00, 8'h00, 4'h1);
    chk({6'h0, got[0][1:0]}, 8'h03, "lock read");
    $display("test delivery done");
  endtask
  task t_array;
    run_cmd(cmdWrite, 8'hff, 8'h5a, 4'h1);
    run_cmd(cmdReadCurrent, 8'h00, 8'h00, 4'h1);
    chk({7'h0, nackSeen}, 8'h01, "ack while busy");
    wait_ready();
    run_cmd(cmdWrite, 8'h00, 8'ha7, 4'h1);
    wait_ready();
    run_cmd(cmdReadRandom, 8'hff, 8'h00, 4'h2);
    chk(got[0], 8'h5a, "random read");
    chk(got[1], 8'ha7, "wrap read");
    chk({7'h0, nackSeen}, 8'h00, "read acked");
    run_cmd(cmdReadCurrent, 8'h00, 8'h00, 4'h1);
    chk(got[0], 8'hff, "current read");
    $display("test array done");
  endtask
  task t_hw_protect;
    @(posedge clk);
    writeProtect <= 1'b1;
    run_cmd(cmdWrite, 8'h90, 8'h33, 4'h1);
    chk({7'h0, nackSeen}, 8'h01, "protected write");
    wait_ready();
    run_cmd(cmdPermSet, 8'h00, 8'h00, 4'h1);
    chk({7'h0, nackSeen}, 8'h01, "protected flip");
    wait_ready();
    chk({7'h0, permanentLockFlag}, 8'h00, "flag kept");
    run_cmd(cmdRevClear, 8'h00, 8'h00, 4'h1);
    chk({7'h0, nackSeen}, 8'h01, "reaffirm");
    @(posedge clk);
    writeProtect <= 1'b0;
    run_cmd(cmdReadRandom, 8'h90, 8'h00, 4'h1);
    chk(got[0], 8'hff, "not written");
    $display("test hw protect done");
  endtask
  task t_rev_lock;
    run_cmd(cmdRevSet, 8'h00, 8'h00, 4'h1);
    chk({7'h0, nackSeen}, 8'h00, "rev set");
    wait_ready();
    chk({7'h0, reversibleLockFlag}, 8'h01, "rev flag");
    run_cmd(cmdRevSet, 8'h00, 8'h00, 4'h1);
    chk({7'h0, nackSeen}, 8'h01, "rev reaffirm");
    run_cmd(cmdWrite, 8'h7f, 8'h11, 4'h1);
    chk({7'h0, nackSeen}, 8'h01, "lower write");
    wait_ready();
    run_cmd(cmdWrite, 8'h80, 8'h22, 4'h1);
    chk({7'h0, nackSeen}, 8'h00, "upper write");
    wait_ready();
    run_cmd(cmdReadRandom, 8'h7f, 8'h00, 4'h2);
    chk(got[0], 8'hff, "lower kept");
    chk(got[1], 8'h22, "upper written");
    run_cmd(cmdLockRead, 8'h00, 8'h00, 4'h1);
    chk({6'h0, got[0][1:0]}, 8'h02, "lock read rev");
    run_cmd(cmdRevClear, 8'h00, 8'h00, 4'h1);
    wait_ready();
    chk({7'h0, reversibleLockFlag}, 8'h00, "rev clear");
    $display("test rev lock done");
  endtask
  task t_perm_lock;
    run_cmd(cmdPermSet, 8'h3c, 8'hc3, 4'h1);
    chk({7'h0, nackSeen}, 8'h00, "perm set acked");
    wait_ready();
    chk({7'h0, permanentLockFlag}, 8'h01, "perm flag");
    run_cmd(cmdPermSet, 8'h00, 8'h00, 4'h1);
    chk({7'h0, nackSeen}, 8'h01, "perm again");
    run_cmd(cmdRevSet, 8'h00, 8'h00, 4'h1);
    chk({7'h0, nackSeen}, 8'h01, "rev after perm");
    run_cmd(cmdLockRead, 8'h00, 8'h00, 4'h1);
    chk({6'h0, got[0][1:0]}, 8'h01, "lock read perm");
    chk({7'h0, permanentLockFlag}, 8'h01, "perm stays");
    $display("test perm lock done");
  endtask
  // ====================
  // Main sequence
  initial begin
    resetn = 1'b0;
    writeProtect = 1'b0;
    selectCfg = 3'h5;
    cmdValid = 1'b0;
    cmdKind = cmdWrite;
    cmdAddr = 8'h00;
    cmdData = 8'h00;
    cmdCount = 4'h1;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
    t_delivery();
    t_array();
    t_hw_protect();
    t_rev_lock();
    t_perm_lock();
    stop_test();
  end
endmodule
`default_nettype wire
